// ==== inc/pmursm_pkg.sv ====
// package for the power event pending and resume control block
// assumes a 40 MHz clock and an axi4-lite master with 32-bit data
// Summary of operation
// - set pending bit per nmi source: d6 sleep act down to d1 external.
// - with lb2 routed to a pin, low battery is the second source.
// - after power good, wait 0, 62.5, 125 or 250 ms before restart.
// - delay field is bits 7:6 of resume control, resets to 11.
// - ignored resume on low battery gives one beep; notify if d5.
// - aborted resume gives two beeps; notify if d4 set.
// - inhibit bit d3 ignores resume requests while low battery active.
// - abort bit d2 abandons resume if first low battery before power good.
// - abort bit d1 abandons resume if no power good within 1 s.
// - control bits d5..d1 reset to zero; d0 reserved.
// - writing one clears a pending bit; zero leaves it.
// - nmi output while global mask clear and an unmasked source set.
package pmursm_pkg;
  localparam logic [7:0] RESUME_CONTROL_IDX = 8'hdd;
  localparam logic [7:0] PENDING_IDX        = 8'hdc;
  localparam logic [7:0] NMI_MASK_IDX       = 8'hc4;
  localparam logic [7:0] IRQ_STATUS_IDX     = 8'he0;
  localparam logic [7:0] IRQ_MASK_IDX       = 8'he1;
  localparam logic [9:0] RESUME_CONTROL_ADDR = {RESUME_CONTROL_IDX, 2'b00};
  localparam logic [9:0] PENDING_ADDR        = {PENDING_IDX, 2'b00};
  localparam logic [9:0] NMI_MASK_ADDR       = {NMI_MASK_IDX, 2'b00};
  localparam logic [9:0] IRQ_STATUS_ADDR     = {IRQ_STATUS_IDX, 2'b00};
  localparam logic [9:0] IRQ_MASK_ADDR       = {IRQ_MASK_IDX, 2'b00};
  localparam logic [7:0] RESUME_CONTROL_RST = 8'hc0;
  localparam logic [7:0] RESUME_CONTROL_WMASK = 8'hfe;
  localparam logic [7:0] PENDING_WMASK = 8'h7e;
  localparam logic [7:0] NMI_MASK_WMASK = 8'hfe;
  localparam int unsigned GLOBAL_MASK_BIT = 7;
  localparam int unsigned DLY_HI = 7;
  localparam int unsigned DLY_LO = 6;
  localparam int unsigned LB_NOTIFY_BIT = 5;
  localparam int unsigned PWG_NOTIFY_BIT = 4;
  localparam int unsigned LB_INHIBIT_BIT = 3;
  localparam int unsigned LOW_BATTERY_RESUME_ABORT_BIT = 2;
  localparam int unsigned POWER_GOOD_TIMEOUT_ABORT_BIT = 1;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned DLY_US_1 = 62500;
  localparam int unsigned DLY_US_2 = 125000;
  localparam int unsigned DLY_US_3 = 250000;
  localparam int unsigned PWG_TIMEOUT_US = 1000000;
  localparam int unsigned BEEP_US = 100000;
  localparam int unsigned GAP_US = 100000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1000000;
  localparam int unsigned DLY_CYC_1 = DLY_US_1 * CYC_PER_US;
  localparam int unsigned DLY_CYC_2 = DLY_US_2 * CYC_PER_US;
  localparam int unsigned DLY_CYC_3 = DLY_US_3 * CYC_PER_US;
  localparam int unsigned PWG_TIMEOUT_CYC = PWG_TIMEOUT_US * CYC_PER_US;
  localparam int unsigned BEEP_CYC = BEEP_US * CYC_PER_US;
  localparam int unsigned GAP_CYC = GAP_US * CYC_PER_US;
  localparam int unsigned CNT_W = 26;
  localparam logic [2:0] IRQ_RESUME_DONE = 3'b001;
  localparam logic [2:0] IRQ_IGNORED     = 3'b010;
  localparam logic [2:0] IRQ_ABORTED     = 3'b100;

  typedef enum logic [4:0] {
    RS_IDLE  = 5'b00001,
    RS_POWER = 5'b00010,
    RS_DELAY = 5'b00100,
    RS_RUN   = 5'b01000,
    RS_ABORT = 5'b10000
  } pmursm_state_t;

  typedef struct packed {
    logic       sleep_activity;
    logic       suspend_timeout;
    logic       sleep_timeout;
    logic       low_battery_two;
    logic       low_battery_one;
    logic       external_request;
  } pmursm_nmi_src_t;

  typedef struct packed {
    logic       system_power_request;
    logic       system_restart;
    logic       speaker;
    logic       system_notify;
  } pmursm_power_out_t;
endpackage : pmursm_pkg

// ==== core/pmursm_beeper.sv ====
// beep pattern generator: one or two beeps on request
// assumes requests only while idle; others are dropped
`timescale 1ns/100ps
module pmursm_beeper #(
  parameter int unsigned BEEP_CYC = pmursm_pkg::BEEP_CYC,
  parameter int unsigned GAP_CYC  = pmursm_pkg::GAP_CYC
) (
  input  wire logic clock_i,
  input  wire logic srst_i,
  input  wire logic one_i,
  input  wire logic two_i,
  output logic      speaker_o,
  output logic      busy_o
);
  typedef struct packed {
    logic [pmursm_pkg::CNT_W-1:0] cnt;
    logic [1:0]                   left;
    logic                         tone;
  } pmursm_beep_t;

  pmursm_beep_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (s_q.left == 2'd0) begin
      if (one_i || two_i) begin
        s_d.left = two_i ? 2'd2 : 2'd1;
        s_d.tone = 1'b1;
        s_d.cnt  = pmursm_pkg::CNT_W'(BEEP_CYC - 1);
      end
    end else if (s_q.cnt != '0) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end else if (s_q.tone) begin
      s_d.tone = 1'b0;
      s_d.cnt  = pmursm_pkg::CNT_W'(GAP_CYC - 1);
    end else begin
      s_d.left = s_q.left - 2'd1;
      if (s_q.left == 2'd2) begin
        s_d.tone = 1'b1;
        s_d.cnt  = pmursm_pkg::CNT_W'(BEEP_CYC - 1);
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign speaker_o = s_q.tone;
  assign busy_o    = s_q.left != 2'd0;
endmodule : pmursm_beeper

// ==== core/pmursm_top.sv ====
// pending flags, nmi gating, resume sequencer, axi4-lite registers
// assumes all inputs synchronous to clock_i; one access of each kind
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/100ps
module pmursm_top #(
  parameter int unsigned DLY_CYC_1       = pmursm_pkg::DLY_CYC_1,
  parameter int unsigned DLY_CYC_2       = pmursm_pkg::DLY_CYC_2,
  parameter int unsigned DLY_CYC_3       = pmursm_pkg::DLY_CYC_3,
  parameter int unsigned PWG_TIMEOUT_CYC = pmursm_pkg::PWG_TIMEOUT_CYC,
  parameter int unsigned BEEP_CYC        = pmursm_pkg::BEEP_CYC,
  parameter int unsigned GAP_CYC         = pmursm_pkg::GAP_CYC
) (
  input  wire logic        clock_i,
  input  wire logic        srst_i,
  input  wire logic [11:0] s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [11:0] s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  input  wire logic [5:0]  nmi_event_i,
  input  wire logic        low_battery_in_i,
  input  wire logic        low_battery_one_in_i,
  input  wire logic        low_battery_two_in_i,
  input  wire logic        lb2_on_pin_i,
  input  wire logic        resume_request_i,
  input  wire logic        system_power_good_i,
  output logic             nmi_o,
  output logic             system_power_request_o,
  output logic             system_restart_o,
  output logic             speaker_o,
  output logic             system_notify_o,
  output logic             irq_o
);
  typedef struct packed {
    pmursm_pkg::pmursm_state_t    st;
    logic [pmursm_pkg::CNT_W-1:0] cnt;
    logic [7:0]                   ctrl;
    logic [7:0]                   pend;
    logic [7:0]                   nmask;
    logic [2:0]                   ist;
    logic [2:0]                   imask;
    logic                         aw_got;
    logic                         w_got;
    logic                         awrdy;
    logic                         wrdy;
    logic                         ardy;
    logic [9:0]                   waddr;
    logic [31:0]                  wdata;
    logic [3:0]                   wstrb;
    logic                         bvalid;
    logic [1:0]                   bresp;
    logic                         rvalid;
    logic [31:0]                  rdata;
    logic [1:0]                   rresp;
    logic                         nmi;
    logic                         irq;
    logic                         beep1;
    logic                         beep2;
    pmursm_pkg::pmursm_power_out_t po;
  } pmursm_state_all_t;

  pmursm_state_all_t s_q, s_d;
  logic             speaker_w;
  pmursm_pkg::pmursm_nmi_src_t src_w;
  logic [7:0]       src_bits_w;
  logic             lb_eff_w;
  logic [pmursm_pkg::CNT_W-1:0] dly_w;

  pmursm_beeper #(
    .BEEP_CYC (BEEP_CYC),
    .GAP_CYC  (GAP_CYC)
  ) u_beeper (
    .clock_i   (clock_i),
    .srst_i    (srst_i),
    .one_i     (s_q.beep1),
    .two_i     (s_q.beep2),
    .speaker_o (speaker_w),
    .busy_o    ()
  );

  // lb routed to the pin redefines the resume low battery as lb2
  assign lb_eff_w = lb2_on_pin_i ? low_battery_two_in_i
                                 : low_battery_in_i;

  always_comb begin
    src_w = nmi_event_i;
    src_w.low_battery_two = nmi_event_i[2] |
                            (lb2_on_pin_i & low_battery_two_in_i);
  end
  assign src_bits_w = {1'b0, src_w, 1'b0};

  always_comb begin
    case (s_q.ctrl[pmursm_pkg::DLY_HI:pmursm_pkg::DLY_LO])
      2'b00:   dly_w = '0;
      2'b01:   dly_w = pmursm_pkg::CNT_W'(DLY_CYC_1);
      2'b10:   dly_w = pmursm_pkg::CNT_W'(DLY_CYC_2);
      default: dly_w = pmursm_pkg::CNT_W'(DLY_CYC_3);
    endcase
  end

  always_comb begin
    logic       wr_go;
    logic       rd_go;
    logic [7:0] wb;
    logic [2:0] iev;
    logic [9:0] ra;
    s_d   = s_q;
    wr_go = 1'b0;
    rd_go = 1'b0;
    wb    = 8'h00;
    iev   = 3'b000;
    // address bits above the map are ignored, so the map aliases upward
    ra    = {s_axi_araddr_i[9:2], 2'b00};
    s_d.beep1 = 1'b0;
    s_d.beep2 = 1'b0;
    s_d.po.system_notify = 1'b0;

    // resume sequencer
    case (s_q.st)
      pmursm_pkg::RS_IDLE: begin
        s_d.po.system_power_request = 1'b0;
        s_d.po.system_restart = 1'b0;
        if (resume_request_i) begin
          if (s_q.ctrl[pmursm_pkg::LB_INHIBIT_BIT] && lb_eff_w) begin
            s_d.beep1 = 1'b1;
            s_d.po.system_notify =
              s_q.ctrl[pmursm_pkg::LB_NOTIFY_BIT];
            iev = iev | pmursm_pkg::IRQ_IGNORED;
          end else begin
            s_d.st = pmursm_pkg::RS_POWER;
            s_d.po.system_power_request = 1'b1;
            s_d.cnt = pmursm_pkg::CNT_W'(PWG_TIMEOUT_CYC - 1);
          end
        end
      end
      pmursm_pkg::RS_POWER: begin
        if (system_power_good_i) begin
          s_d.st  = pmursm_pkg::RS_DELAY;
          s_d.cnt = dly_w;
        end else if ((s_q.ctrl[pmursm_pkg::LOW_BATTERY_RESUME_ABORT_BIT] &&
                      low_battery_one_in_i) ||
                     (s_q.ctrl[pmursm_pkg::POWER_GOOD_TIMEOUT_ABORT_BIT] &&
                      s_q.cnt == '0)) begin
          s_d.st = pmursm_pkg::RS_ABORT;
        end else if (s_q.cnt != '0) begin
          s_d.cnt = s_q.cnt - 1'b1;
        end
      end
      pmursm_pkg::RS_DELAY: begin
        if (s_q.cnt == '0) begin
          s_d.st = pmursm_pkg::RS_RUN;
          s_d.po.system_restart = 1'b1;
          iev = iev | pmursm_pkg::IRQ_RESUME_DONE;
        end else begin
          s_d.cnt = s_q.cnt - 1'b1;
        end
      end
      pmursm_pkg::RS_RUN: begin
        // system runs until power good is lost
        if (!system_power_good_i) begin
          s_d.st = pmursm_pkg::RS_IDLE;
          s_d.po.system_restart = 1'b0;
          s_d.po.system_power_request = 1'b0;
        end
      end
      pmursm_pkg::RS_ABORT: begin
        s_d.st = pmursm_pkg::RS_IDLE;
        s_d.po.system_power_request = 1'b0;
        s_d.beep2 = 1'b1;
        s_d.po.system_notify =
          s_q.ctrl[pmursm_pkg::PWG_NOTIFY_BIT];
        iev = iev | pmursm_pkg::IRQ_ABORTED;
      end
      default: s_d.st = pmursm_pkg::RS_IDLE;
    endcase

    // axi write path: address and data in either order
    s_d.po.speaker = speaker_w;
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      s_d.aw_got = 1'b1;
      s_d.waddr  = {s_axi_awaddr_i[9:2], 2'b00};
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      s_d.w_got = 1'b1;
      s_d.wdata = s_axi_wdata_i;
      s_d.wstrb = s_axi_wstrb_i;
    end
    if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
      wr_go      = 1'b1;
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = pmursm_pkg::RESP_OKAY;
      wb = s_q.wstrb[0] ? s_q.wdata[7:0] : 8'h00;
    end
    if (s_q.bvalid && s_axi_bready_i) begin
      s_d.bvalid = 1'b0;
    end

    // pending flags: set wins over a same-cycle clear
    if (wr_go && s_q.waddr == pmursm_pkg::PENDING_ADDR) begin
      s_d.pend = s_q.pend & ~(wb & pmursm_pkg::PENDING_WMASK);
    end
    s_d.pend = s_d.pend | src_bits_w;

    if (wr_go) begin
      if (s_q.waddr == pmursm_pkg::RESUME_CONTROL_ADDR) begin
        if (s_q.wstrb[0]) begin
          s_d.ctrl = wb & pmursm_pkg::RESUME_CONTROL_WMASK;
        end
      end else if (s_q.waddr == pmursm_pkg::NMI_MASK_ADDR) begin
        if (s_q.wstrb[0]) begin
          s_d.nmask = wb & pmursm_pkg::NMI_MASK_WMASK;
        end
      end else if (s_q.waddr == pmursm_pkg::IRQ_MASK_ADDR) begin
        if (s_q.wstrb[0]) begin
          s_d.imask = wb[2:0];
        end
      end else if (s_q.waddr != pmursm_pkg::PENDING_ADDR &&
                   s_q.waddr != pmursm_pkg::IRQ_STATUS_ADDR) begin
        s_d.bresp = pmursm_pkg::RESP_SLVERR;
      end
    end

    // axi read path; reading the irq status clears it
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      rd_go      = 1'b1;
      s_d.rvalid = 1'b1;
      s_d.rresp  = pmursm_pkg::RESP_OKAY;
      s_d.rdata  = 32'h0000_0000;
      if (ra == pmursm_pkg::RESUME_CONTROL_ADDR) begin
        s_d.rdata[7:0] = s_q.ctrl;
      end else if (ra == pmursm_pkg::PENDING_ADDR) begin
        s_d.rdata[7:0] = s_q.pend;
      end else if (ra == pmursm_pkg::NMI_MASK_ADDR) begin
        s_d.rdata[7:0] = s_q.nmask;
      end else if (ra == pmursm_pkg::IRQ_STATUS_ADDR) begin
        s_d.rdata[2:0] = s_q.ist;
      end else if (ra == pmursm_pkg::IRQ_MASK_ADDR) begin
        s_d.rdata[2:0] = s_q.imask;
      end else begin
        s_d.rresp = pmursm_pkg::RESP_SLVERR;
      end
    end
    if (s_q.rvalid && s_axi_rready_i) begin
      s_d.rvalid = 1'b0;
    end
    if (rd_go && ra == pmursm_pkg::IRQ_STATUS_ADDR) begin
      s_d.ist = 3'b000;
    end
    s_d.ist = s_d.ist | iev;
    s_d.irq = |(s_d.ist & s_d.imask);

    // nmi held while global mask clear and an unmasked source pending
    s_d.nmi = !s_d.nmask[pmursm_pkg::GLOBAL_MASK_BIT] &&
              (|(s_d.pend & ~s_d.nmask));

    // ready flags kept in flops so bus outputs need no gate
    s_d.awrdy = !s_d.aw_got;
    s_d.wrdy  = !s_d.w_got;
    s_d.ardy  = !s_d.rvalid;
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      s_q      <= '0;
      s_q.st   <= pmursm_pkg::RS_IDLE;
      s_q.ctrl <= pmursm_pkg::RESUME_CONTROL_RST;
      s_q.awrdy <= 1'b1;
      s_q.wrdy  <= 1'b1;
      s_q.ardy  <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready_o        = s_q.awrdy;
  assign s_axi_wready_o         = s_q.wrdy;
  assign s_axi_bvalid_o         = s_q.bvalid;
  assign s_axi_bresp_o          = s_q.bresp;
  assign s_axi_arready_o        = s_q.ardy;
  assign s_axi_rvalid_o         = s_q.rvalid;
  assign s_axi_rdata_o          = s_q.rdata;
  assign s_axi_rresp_o          = s_q.rresp;
  assign nmi_o                  = s_q.nmi;
  assign irq_o                  = s_q.irq;
  assign system_power_request_o = s_q.po.system_power_request;
  assign system_restart_o       = s_q.po.system_restart;
  assign speaker_o              = s_q.po.speaker;
  assign system_notify_o        = s_q.po.system_notify;
endmodule : pmursm_top

// ==== verif/pmursm_psu_model.sv ====
// supply model: power good follows the power request after a set delay
// assumes the bench picks the delay; delay 0 models a dead supply
`timescale 1ns/100ps
module pmursm_psu_model (
  input  wire logic       clock_i,
  input  wire logic       req_i,
  input  wire logic [7:0] dly_i,
  output logic            pg_o
);
  logic [7:0] cnt_q;
  initial cnt_q = 8'h00;
  initial pg_o = 1'b0;
  // good drops on the clock after the request falls, never lingers
  always @(posedge clock_i) begin
    if (!req_i) cnt_q <= 8'h00;
    else if (cnt_q != 8'hff) cnt_q <= cnt_q + 8'h01;
    pg_o <= req_i && dly_i != 8'h00 && cnt_q >= dly_i;
  end
endmodule : pmursm_psu_model

// ==== verif/pmursm_props.sv ====
// checker for the resume sequencer, bound to the top module
// assumes control writes finish before a resume is requested
`timescale 1ns/100ps
module pmursm_props #(
  parameter int unsigned DLY_CYC_1       = 20,
  parameter int unsigned DLY_CYC_2       = 40,
  parameter int unsigned DLY_CYC_3       = 80,
  parameter int unsigned PWG_TIMEOUT_CYC = 100
) (
  input wire logic        clock_i,
  input wire logic        srst_i,
  input wire logic [11:0] s_axi_awaddr_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic        low_battery_in_i,
  input wire logic        low_battery_one_in_i,
  input wire logic        lb2_on_pin_i,
  input wire logic        system_power_good_i,
  input wire logic        system_power_request_o,
  input wire logic        system_restart_o,
  input wire logic        speaker_o,
  input wire logic        system_notify_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  logic [7:0]  ctl_q;
  logic [7:0]  wd_q;
  logic [11:0] wa_q;
  logic [31:0] pgc_q;
  logic [31:0] wtc_q;
  int unsigned dly;
  assign dly = ctl_q[7] ? (ctl_q[6] ? DLY_CYC_3 : DLY_CYC_2)
                        : (ctl_q[6] ? DLY_CYC_1 : 0);
  // shadow of the control register, taken from completed okay writes
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ctl_q <= pmursm_pkg::RESUME_CONTROL_RST;
      pgc_q <= '0;
      wtc_q <= '0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) wa_q <= s_axi_awaddr_i;
      if (s_axi_wvalid_i && s_axi_wready_o) wd_q <= s_axi_wdata_i[7:0];
      if (s_axi_bvalid_o && s_axi_bready_i &&
          s_axi_bresp_o == pmursm_pkg::RESP_OKAY &&
          wa_q == {2'b00, pmursm_pkg::RESUME_CONTROL_ADDR})
        ctl_q <= wd_q & pmursm_pkg::RESUME_CONTROL_WMASK;
      pgc_q <= (system_power_request_o && system_power_good_i &&
                !system_restart_o) ? pgc_q + 32'h1 : '0;
      wtc_q <= (system_power_request_o && !system_power_good_i)
               ? wtc_q + 32'h1 : '0;
    end
  end
  sequence s_powered;
    system_power_request_o && system_power_good_i;
  endsequence
  sequence s_waiting;
    system_power_request_o && !system_power_good_i;
  endsequence
  chk_restart_powered: assert property (
    system_restart_o |-> system_power_request_o)
    else $error("restart without power request");
  chk_restart_drop: assert property (
    $fell(system_power_good_i) |=> !system_restart_o)
    else $error("restart held after power good loss");
  chk_delay_min: assert property (
    $rose(system_restart_o) |-> pgc_q >= dly)
    else $error("restart before the resume delay");
  chk_delay_max: assert property (
    s_powered ##0 !system_restart_o |-> pgc_q <= dly + 3)
    else $error("restart later than the resume delay");
  chk_pg_timeout: assert property (
    s_waiting ##0 ctl_q[1] |-> wtc_q <= PWG_TIMEOUT_CYC + 4)
    else $error("no abort after power good time-out");
  chk_low_battery_resume_abort: assert property (
    s_waiting ##0 ($past(system_power_request_o) &&
    low_battery_one_in_i && ctl_q[2]) |-> ##[1:3] !system_power_request_o)
    else $error("no abort on low battery before power good");
  chk_inhibit: assert property (
    ctl_q[3] && low_battery_in_i && !lb2_on_pin_i &&
    !system_power_request_o |=> !system_power_request_o)
    else $error("resume accepted while inhibited");
  chk_notify_gate: assert property (
    system_notify_o |-> ctl_q[5] || ctl_q[4])
    else $error("notify with both enables clear");
  chk_quiet_run: assert property (
    system_restart_o |-> !speaker_o && !system_notify_o)
    else $error("beep or notify during a good resume");
endmodule : pmursm_props

bind pmursm_top pmursm_props #(
  .DLY_CYC_1(DLY_CYC_1),
  .DLY_CYC_2(DLY_CYC_2),
  .DLY_CYC_3(DLY_CYC_3),
  .PWG_TIMEOUT_CYC(PWG_TIMEOUT_CYC)
) pmursm_props_i (.clock_i, .srst_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
  .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wvalid_i, .s_axi_wready_o,
  .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .low_battery_in_i,
  .low_battery_one_in_i, .lb2_on_pin_i, .system_power_good_i,
  .system_power_request_o, .system_restart_o, .speaker_o,
  .system_notify_o);

// ==== verif/pmursm_top_tb.sv ====
// self-checking bench: registers, pending flags, nmi, resume paths
// assumes shortened delays; the supply model answers power requests
`timescale 1ns/100ps
module pmursm_top_tb;
  localparam int D1 = 20, D2 = 40, D3 = 80;
  localparam logic [11:0] A_CTL = {2'b00, pmursm_pkg::RESUME_CONTROL_ADDR};
  localparam logic [11:0] A_PND = {2'b00, pmursm_pkg::PENDING_ADDR};
  localparam logic [11:0] A_NMK = {2'b00, pmursm_pkg::NMI_MASK_ADDR};
  localparam logic [11:0] A_IST = {2'b00, pmursm_pkg::IRQ_STATUS_ADDR};
  localparam logic [11:0] A_IMK = {2'b00, pmursm_pkg::IRQ_MASK_ADDR};
  localparam logic [1:0] OK = pmursm_pkg::RESP_OKAY;
  int dl [4] = '{0, D1, D2, D3};
  logic clock_i = 1'b0, srst_i = 1'b1;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, rs = 32'd90;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, pg, spk_q = 0;
  logic [1:0] bresp, rresp;
  logic [5:0] ev = '0, p;
  logic lb = 0, lb1 = 0, lb2 = 0, lbpin = 0, rsm = 0;
  logic nmi, preq, rst_o, spk, note, irq;
  logic [7:0] pdly = '0, im = '0;
  logic [33:0] rq[$], bq[$];
  int err_total = 0, cmp_count = 0, cyc = 0, beeps, notes, seen;
  always #12.5 clock_i = ~clock_i;
  pmursm_top #(.DLY_CYC_1(D1), .DLY_CYC_2(D2), .DLY_CYC_3(D3),
    .PWG_TIMEOUT_CYC(100), .BEEP_CYC(5), .GAP_CYC(5)) pmursm_top_i (
    .clock_i, .srst_i, .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .nmi_event_i(ev), .low_battery_in_i(lb), .low_battery_one_in_i(lb1),
    .low_battery_two_in_i(lb2), .lb2_on_pin_i(lbpin),
    .resume_request_i(rsm), .system_power_good_i(pg), .nmi_o(nmi),
    .system_power_request_o(preq), .system_restart_o(rst_o),
    .speaker_o(spk), .system_notify_o(note), .irq_o(irq));
  pmursm_psu_model pmursm_psu_model_i (.clock_i, .req_i(preq),
    .dly_i(pdly), .pg_o(pg));
  task automatic end_sim;
    $display("mismatches %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // results are compared when the bus hands them back, oldest first
  always @(posedge clock_i) begin
    spk_q <= spk;
    if (spk && !spk_q) beeps++;
    if (note) notes++;
    if (preq) seen = 1;
    if (rvalid && rready) chk({rresp, rdata}, rq.pop_front());
    if (bvalid && bready) chk({bresp, 32'h0}, bq.pop_front());
    if (++cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic ap, wp;
    bq.push_back({OK, 32'h0});
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    ap = 1'b1;
    wp = 1'b1;
    while (ap || wp) begin
      @(posedge clock_i);
      if (ap && awready) begin
        ap = 1'b0;
        awvalid <= 1'b0;
      end
      if (wp && wready) begin
        wp = 1'b0;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge clock_i); while (!bvalid);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] d,
                    input logic [1:0] r);
    rq.push_back({r, 24'h0, d});
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clock_i); while (!arready);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge clock_i); while (!rvalid);
    rready <= 1'b0;
  endtask : rd
  task automatic nchk(input logic e);
    repeat (2) @(posedge clock_i);
    chk(nmi, e);
  endtask : nchk
  // kind: 0 restarts, 1 ignored (one beep), 2 aborted (two beeps)
  task automatic resume(input logic [7:0] c, input logic [7:0] d,
                        input int kind, input int nn);
    int n;
    wr(A_CTL, c);
    pdly <= d;
    beeps = 0;
    notes = 0;
    seen = 0;
    n = 0;
    rsm <= 1'b1;
    @(posedge clock_i);
    rsm <= 1'b0;
    if (kind == 0) begin
      while (!pg) @(posedge clock_i);
      while (!rst_o) begin
        @(posedge clock_i);
        n++;
      end
      chk(n >= dl[c[7:6]] && n <= dl[c[7:6]] + 3, 1'b1);
      pdly <= 8'h00;
    end else repeat (300) @(posedge clock_i);
    repeat (60) @(posedge clock_i);
    chk({preq, rst_o}, 2'b00);
    chk(seen, kind != 1);
    chk(beeps, kind);
    chk(notes, nn);
    // an irq mask bit set enables that status bit onto irq
    chk(irq, im[kind]);
    rd(A_IST, 8'h01 << kind, OK);
    @(posedge clock_i);
    chk(irq, 1'b0);
  endtask : resume
  initial begin
    repeat (3) @(posedge clock_i);
    srst_i <= 1'b0;
    @(posedge clock_i);
    rd(A_CTL, 8'hc0, OK);
    rd(A_PND, 8'h00, OK);
    rd(12'h004, 8'h00, pmursm_pkg::RESP_SLVERR);
    wr(A_CTL, 8'hff);
    rd(A_CTL, 8'hfe, OK);
    wr(A_NMK, 8'h00);
    wr(A_IMK, 8'h00);
    for (int i = 0; i < 6; i++) begin
      ev <= 6'h01 << i;
      @(posedge clock_i);
      ev <= 6'h00;
      wr(A_PND, 8'h00);
      rd(A_PND, 8'h02 << i, OK);
      nchk(1'b1);
      wr(A_NMK, 8'h02 << i);
      nchk(1'b0);
      wr(A_NMK, 8'h80);
      nchk(1'b0);
      wr(A_NMK, 8'h00);
      wr(A_PND, 8'h02 << i);
      rd(A_PND, 8'h00, OK);
      nchk(1'b0);
    end
    for (int k = 0; k < 4; k++) begin
      rs = xs(rs);
      p = rs[5:0];
      ev <= p;
      @(posedge clock_i);
      ev <= 6'h00;
      rs = xs(rs);
      wr(A_PND, rs[7:0]);
      rd(A_PND, {1'b0, p, 1'b0} & ~rs[7:0], OK);
      wr(A_PND, 8'h7e);
    end
    for (int j = 0; j < 2; j++) begin
      lbpin <= j[0];
      lb2 <= 1'b1;
      @(posedge clock_i);
      lb2 <= 1'b0;
      rd(A_PND, j[0] ? 8'h08 : 8'h00, OK);
      wr(A_PND, 8'h7e);
    end
    lbpin <= 1'b0;
    for (int d = 0; d < 4; d++) resume({d[1:0], 6'h00}, 8'd10, 0, 0);
    lb <= 1'b1;
    resume(8'h28, 8'd10, 1, 1);
    resume(8'h08, 8'd10, 1, 0);
    resume(8'h00, 8'd10, 0, 0);
    lb <= 1'b0;
    lb1 <= 1'b1;
    resume(8'h14, 8'd0, 2, 1);
    resume(8'h00, 8'd10, 0, 0);
    lb1 <= 1'b0;
    im = 8'h07;
    wr(A_IMK, im);
    resume(8'h02, 8'd0, 2, 0);
    end_sim();
  end
endmodule : pmursm_top_tb
